/* File: hw/esc_serial_cmd.sv */
`timescale 1ns/100ps
// How it works
// - Three-wire transaction starts at chip select rise.
// - Three-wire: chip select low holds interface in reset.
// - Two-wire: clock timeout resets the interface.
// - Three-wire: chain output marks cycle end.
// - Two-wire chain: first fall sets, end clears.
// - First command bit selects write or read.
// - Code 10111 loads sleep, soft reset, hysteresis.
// - Preset and read turn counter with fuse flag.
// - Code 10000 with key enables extended mode.
// - Code 00000 returns lock, gain, angle.
// - Sleep bit controls sleep; registers kept.
// - Lock flag reads low during sleep.
// - Hysteresis codes map to 2,1,3,0 LSB.
// - Code 11111 soft-writes the fuse word.
// - Code 11001 programs bits 0-20 unless locked.
// - Code 01111 reads back the fuse word.
// - Code 01001 streams fuse bits on programming pin.
// - Fuse word fields: zero, poles, abi, gain, redundancy.
// - Extended data bits last four clocks each.
// - Normal frame: 5-bit command, 16 data bits.
module esc_serial_cmd #(
  parameter int TIMEOUT_CYC = esc_pkg::TIMEOUT_CYC,
  parameter logic [61:0] FUSE_INIT = esc_pkg::FUSE_RESET
) (
  input wire logic SYS_CLK, // 20 MHz system clock
  input wire logic RST_N, // Asynchronous reset, active low
  input wire logic CHIP_SELECT, // Three-wire frame select pin
  input wire logic SERIAL_CLOCK_IN, // Serial clock pin
  input wire logic SERIAL_DATA_IN, // Data line level
  output logic SERIAL_DATA_OUT, // Data line drive value
  output logic SERIAL_DATA_OE_N, // Data line enable, low drives
  input wire logic FRAMING_SELECT, // Low three-wire, high two-wire
  output logic CHAIN_OUT, // Daisy chain output
  input wire logic [8:0] ANGLE_IN, // Angle from converter
  input wire logic [5:0] AGC_IN, // Gain control value
  input wire logic LOCK_IN, // Converter tracking locked
  input wire logic FUSE_OK_IN, // Fuse readout check result
  output logic SLEEP_REQUEST, // Sleep request bit
  output logic SOFT_RESET, // Soft reset bit
  output logic [1:0] HYST_STEPS, // Hysteresis in LSB
  output logic [8:0] TURN_COUNT, // Multi-turn counter
  output logic EXT_MODE, // Extended mode active
  output logic [61:0] FUSE_WORD, // Shadow fuse word
  output logic FUSE_PROGRAMMING_PIN_STROBE, // One-cycle program request
  output logic [20:0] FUSE_PROGRAMMING_PIN_DATA, // User bits to program
  output logic PROGRAMMING_PIN_OUT, // Fuse bit level during readback
  output logic PROGRAMMING_PIN_OE_N // Programming pin enable, low drives
);
  esc_link_if lnk ();

  esc_link_front #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_front (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .cs_pin(CHIP_SELECT),
    .serial_clock_in_pin(SERIAL_CLOCK_IN),
    .dio_pin(SERIAL_DATA_IN),
    .framing_pin(FRAMING_SELECT),
    .lnk(lnk.front)
  );

  esc_pkg::esc_state_t state;
  logic [5:0] bit_cnt;
  logic [1:0] sub_cnt;
  logic [4:0] cmd;
  logic [61:0] sh;
  logic ext_op;
  logic rd_op;
  logic cap;
  logic drive_n;
  logic ana_n;
  logic [15:0] config_word;
  logic fuse_ok;
  logic ok_caught;
  logic [61:0] read_val;

  wire rx = lnk.serial_clock_in_rise && !lnk.frame_rst;
  wire [4:0] cmd_full = {cmd[3:0], lnk.data_bit};
  wire is_ext = (cmd_full == esc_pkg::CMD_FUSE_WR) || (cmd_full == esc_pkg::CMD_FUSE_PROGRAMMING_PIN)
                || (cmd_full == esc_pkg::CMD_FUSE_RD) || (cmd_full == esc_pkg::CMD_FUSE_ANA);
  wire ext_ok = is_ext && EXT_MODE;
  wire is_rd_known = (cmd_full == esc_pkg::CMD_ANGLE) || (cmd_full == esc_pkg::CMD_TURN_RD)
                     || (ext_ok && cmd_full == esc_pkg::CMD_FUSE_RD);
  wire is_ana = ext_ok && (cmd_full == esc_pkg::CMD_FUSE_ANA);
  wire cmd_end = (state == esc_pkg::ST_CMD) && rx && (bit_cnt == esc_pkg::CMD_LAST);
  wire grp_end = !ext_op || (sub_cnt == esc_pkg::SUB_LAST);
  wire bit_in = ext_op ? cap : lnk.data_bit;
  wire [61:0] word = {sh[60:0], bit_in};
  wire [5:0] last_bit = ext_op ? esc_pkg::FUSE_LAST : esc_pkg::NORM_LAST;
  wire last = grp_end && (bit_cnt == last_bit);
  wire data_end = (state == esc_pkg::ST_DATA) && rx && last;
  wire exec = data_end && !rd_op;
  wire lock_seen = LOCK_IN && !config_word[esc_pkg::CFG_SLEEP_BIT];
  wire [8:0] turn_field = word[esc_pkg::TURN_LSB +: 9];
  wire [15:0] word16 = word[15:0];
  wire fuse_lock = FUSE_WORD[esc_pkg::FUSE_LOCK_BIT];
  wire [1:0] hyst_code = word[esc_pkg::CFG_HYST_LSB +: 2];

  always_comb
  begin
    read_val = '0;
    case (cmd_full)
      esc_pkg::CMD_ANGLE: read_val = {lock_seen, AGC_IN, ANGLE_IN, 46'h0};
      esc_pkg::CMD_TURN_RD: read_val = {TURN_COUNT, fuse_ok, 6'h00, 46'h0};
      esc_pkg::CMD_FUSE_RD: read_val = EXT_MODE ? FUSE_WORD : '0;
      esc_pkg::CMD_FUSE_ANA: read_val = EXT_MODE ? FUSE_WORD : '0;
      default: read_val = '0;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state <= esc_pkg::ST_CMD;
      bit_cnt <= '0;
      sub_cnt <= '0;
      cmd <= '0;
      sh <= '0;
      ext_op <= 1'b0;
      rd_op <= 1'b0;
      cap <= 1'b0;
      drive_n <= 1'b1;
      ana_n <= 1'b1;
    end
    // new frame begins from command receive
    // held idle while the frame is reset
    else if (lnk.frame_rst)
    begin
      state <= esc_pkg::ST_CMD;
      bit_cnt <= '0;
      sub_cnt <= '0;
      drive_n <= 1'b1;
      ana_n <= 1'b1;
    end
    else if (rx)
    begin
      case (state)
        esc_pkg::ST_CMD:
        begin
          cmd <= cmd_full;
          bit_cnt <= cmd_end ? 6'h00 : bit_cnt + 6'h01;
          if (cmd_end)
          begin
            state <= esc_pkg::ST_DATA;
            // extended codes only count in extended mode
            ext_op <= ext_ok;
            rd_op <= ~cmd_full[4];
            sh <= read_val;
            drive_n <= ~is_rd_known;
            ana_n <= ~is_ana;
          end
        end
        esc_pkg::ST_DATA:
        begin
          sub_cnt <= ext_op ? sub_cnt + 2'h1 : 2'h0;
          if (sub_cnt == 2'h0)
            cap <= lnk.data_bit;
          if (grp_end)
          begin
            sh <= word;
            bit_cnt <= bit_cnt + 6'h01;
          end
          // frame ends after its last data bit
          if (last)
          begin
            state <= esc_pkg::ST_DONE;
            drive_n <= 1'b1;
            ana_n <= 1'b1;
          end
        end
        esc_pkg::ST_DONE: state <= esc_pkg::ST_DONE;
        default: state <= esc_pkg::ST_CMD;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      config_word <= esc_pkg::CFG_RESET;
      HYST_STEPS <= esc_pkg::HYST_STEPS_RESET;
      TURN_COUNT <= esc_pkg::TURN_RESET;
      EXT_MODE <= 1'b0;
      FUSE_WORD <= FUSE_INIT;
      FUSE_PROGRAMMING_PIN_STROBE <= 1'b0;
      FUSE_PROGRAMMING_PIN_DATA <= '0;
      fuse_ok <= 1'b0;
      ok_caught <= 1'b0;
    end
    else
    begin
      FUSE_PROGRAMMING_PIN_STROBE <= 1'b0;
      ok_caught <= 1'b1;
      if (!ok_caught || (data_end && ext_op))
        fuse_ok <= FUSE_OK_IN;
      if (exec)
      begin
        case (cmd)
          // sleep bit drives sleep, registers kept
          esc_pkg::CMD_CFG:
          begin
            config_word <= word16;
            HYST_STEPS <= esc_pkg::HYST_MAP[2 * hyst_code +: 2];
          end
          esc_pkg::CMD_TURN_SET: TURN_COUNT <= turn_field;
          esc_pkg::CMD_EXT_EN: EXT_MODE <= EXT_MODE || (word16 == esc_pkg::EXT_KEY);
          esc_pkg::CMD_FUSE_WR: FUSE_WORD <= ext_op ? word : FUSE_WORD;
          // user bits only, blocked by lock bit
          esc_pkg::CMD_FUSE_PROGRAMMING_PIN:
          begin
            if (ext_op && !fuse_lock)
            begin
              FUSE_WORD[esc_pkg::FUSE_USER_BITS-1:0] <= word[esc_pkg::FUSE_USER_BITS-1:0];
              FUSE_PROGRAMMING_PIN_DATA <= word[esc_pkg::FUSE_USER_BITS-1:0];
              FUSE_PROGRAMMING_PIN_STROBE <= 1'b1;
            end
          end
          default: EXT_MODE <= EXT_MODE;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      CHAIN_OUT <= 1'b0;
    else if (lnk.frame_rst)
      CHAIN_OUT <= 1'b0;
    // two-wire chain set on first fall, cleared at end
    else if (lnk.two_wire)
    begin
      if (state == esc_pkg::ST_DONE)
        CHAIN_OUT <= 1'b0;
      else if (lnk.serial_clock_in_fall)
        CHAIN_OUT <= 1'b1;
    end
    else
      CHAIN_OUT <= (state == esc_pkg::ST_DONE);
  end

  assign SERIAL_DATA_OUT = sh[61];
  assign SERIAL_DATA_OE_N = drive_n;
  assign PROGRAMMING_PIN_OUT = sh[61];
  assign PROGRAMMING_PIN_OE_N = ana_n;
  assign SLEEP_REQUEST = config_word[esc_pkg::CFG_SLEEP_BIT];
  assign SOFT_RESET = config_word[esc_pkg::CFG_SRST_BIT];

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  AST_HOLD_RESET: assert property (lnk.frame_rst |=>
    (state == esc_pkg::ST_CMD) && (bit_cnt == 6'h00) && drive_n && ana_n)
    else $error("interface not idle after frame reset");
  AST_CHAIN_3W: assert property ((!lnk.two_wire && !lnk.frame_rst && state == esc_pkg::ST_DONE)
    |=> CHAIN_OUT || lnk.frame_rst)
    else $error("chain output missing at end of three-wire cycle");
  AST_CHAIN_2W: assert property ((lnk.two_wire && !lnk.frame_rst && lnk.serial_clock_in_fall
    && state != esc_pkg::ST_DONE) |=> CHAIN_OUT)
    else $error("two-wire chain output not set on falling clock");
  AST_WRITE_NO_DRIVE: assert property ((cmd_end && cmd_full[4]) |=> drive_n[*2])
    else $error("device drove data during a write access");
  AST_CFG_LOAD: assert property ((exec && cmd == esc_pkg::CMD_CFG) |=>
    (SLEEP_REQUEST == $past(word[15])) && (SOFT_RESET == $past(word[14])))
    else $error("configuration word not loaded");
  AST_TURN_SET: assert property ((exec && cmd == esc_pkg::CMD_TURN_SET) |=>
    TURN_COUNT == $past(turn_field))
    else $error("turn counter preset failed");
  AST_EXT_KEY: assert property ((exec && cmd == esc_pkg::CMD_EXT_EN
    && word16 == esc_pkg::EXT_KEY) |=> EXT_MODE)
    else $error("extended mode not entered");
  AST_LOCK_SLEEP: assert property ((cmd_end && cmd_full == esc_pkg::CMD_ANGLE
    && SLEEP_REQUEST) |=> !sh[61])
    else $error("lock flag read high during sleep");
  AST_PROGRAMMING_PIN_LOCK: assert property (FUSE_PROGRAMMING_PIN_STROBE |-> !$past(fuse_lock))
    else $error("fuse programmed while locked");
  AST_EXT_BIT: assert property ((ext_op && state == esc_pkg::ST_DATA && rx
    && sub_cnt != esc_pkg::SUB_LAST) |=> $stable(sh))
    else $error("extended bit shifted before four clocks");
  AST_EXT_IGNORE: assert property ((cmd_end && is_ext && !EXT_MODE) |=>
    drive_n && ana_n && !ext_op)
    else $error("extended command acted on in normal mode");

  COV_EXT_ENTER: cover property ($rose(EXT_MODE));
  COV_PROGRAMMING_PIN: cover property (FUSE_PROGRAMMING_PIN_STROBE);
  COV_ANGLE_READ: cover property (cmd_end && cmd_full == esc_pkg::CMD_ANGLE);
  COV_CHAIN_2W: cover property (lnk.two_wire && $rose(CHAIN_OUT));
endmodule // esc_serial_cmd

/* File: hw/esc_pkg.sv */
package esc_pkg;
  // System clock and two-wire clock timeout
  localparam int CLK_PERIOD_NS = 50;
  localparam int TIMEOUT_NS = 20000;
  localparam int TIMEOUT_CYC = (TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Frame geometry
  localparam int CMD_BITS = 5;
  localparam int NORM_BITS = 16;
  localparam int FUSE_BITS = 62;
  localparam int EXT_SUB = 4;
  localparam logic [5:0] CMD_LAST = 6'h04;
  localparam logic [5:0] NORM_LAST = 6'h0f;
  localparam logic [5:0] FUSE_LAST = 6'h3d;
  localparam logic [1:0] SUB_LAST = 2'h3;
  // Command codes
  localparam logic [4:0] CMD_CFG = 5'h17;
  localparam logic [4:0] CMD_TURN_SET = 5'h14;
  localparam logic [4:0] CMD_EXT_EN = 5'h10;
  localparam logic [4:0] CMD_TURN_RD = 5'h04;
  localparam logic [4:0] CMD_ANGLE = 5'h00;
  localparam logic [4:0] CMD_FUSE_WR = 5'h1f;
  localparam logic [4:0] CMD_FUSE_PROGRAMMING_PIN = 5'h19;
  localparam logic [4:0] CMD_FUSE_RD = 5'h0f;
  localparam logic [4:0] CMD_FUSE_ANA = 5'h09;
  localparam logic [15:0] EXT_KEY = 16'h8cae;
  // Configuration word fields
  localparam int CFG_SLEEP_BIT = 15;
  localparam int CFG_SRST_BIT = 14;
  localparam int CFG_HYST_LSB = 10;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Hysteresis code to LSB steps, indexed by code: 00->2, 01->1, 10->3, 11->0
  localparam logic [7:0] HYST_MAP = 8'h36;
  localparam logic [1:0] HYST_STEPS_RESET = 2'h2;
  // Turn counter fields
  localparam int TURN_LSB = 7;
  localparam int TURN_OK_BIT = 6;
  localparam logic [8:0] TURN_RESET = 9'h000;
  // Fuse word fields
  localparam int FUSE_LOCK_BIT = 21;
  localparam int FUSE_USER_BITS = 21;
  localparam int FUSE_ZERO_LSB = 0;
  localparam int FUSE_POLE_LSB = 9;
  localparam int FUSE_ABI_LSB = 12;
  localparam int FUSE_GAIN_LSB = 14;
  localparam int FUSE_RBIT = 16;
  localparam int FUSE_RADDR_LSB = 17;
  // Arbitrary neutral power-up image of the fuse word
  localparam logic [61:0] FUSE_RESET = 62'h0;

  typedef enum logic [2:0] {
    ST_CMD = 3'b001,
    ST_DATA = 3'b010,
    ST_DONE = 3'b100
  } esc_state_t;
endpackage

/* File: hw/esc_link_if.sv */
`timescale 1ns/100ps
interface esc_link_if;
  logic serial_clock_in_rise;
  logic serial_clock_in_fall;
  logic data_bit;
  logic frame_rst;
  logic two_wire;
  modport front (output serial_clock_in_rise, serial_clock_in_fall, data_bit, frame_rst, two_wire);
  modport core (input serial_clock_in_rise, serial_clock_in_fall, data_bit, frame_rst, two_wire);
endinterface

/* File: hw/esc_link_front.sv */
`timescale 1ns/100ps
module esc_link_front #(
  parameter int TIMEOUT_CYC = esc_pkg::TIMEOUT_CYC
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic cs_pin, // Chip select pin
  input wire logic serial_clock_in_pin, // Serial clock pin
  input wire logic dio_pin, // Serial data pin level
  input wire logic framing_pin, // Framing select pin
  esc_link_if.front lnk // Synchronised link events
);
  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] QUIET_MAX = CW'(TIMEOUT_CYC);

  logic [3:0] raw;
  logic [3:0] meta;
  logic [3:0] sync;
  logic serial_clock_in_d;
  logic [CW-1:0] quiet_cnt;

  assign raw = {framing_pin, dio_pin, serial_clock_in_pin, cs_pin};

  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_sync
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta[i] <= 1'b0;
          sync[i] <= 1'b0;
        end
        else
        begin
          meta[i] <= raw[i];
          sync[i] <= meta[i];
        end
      end
    end
  endgenerate

  wire edge_now = sync[1] ^ serial_clock_in_d;
  wire quiet_full = (quiet_cnt == QUIET_MAX);
  wire next_expired = !edge_now && quiet_full;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_clock_in_d <= 1'b0;
      quiet_cnt <= QUIET_MAX;
      lnk.serial_clock_in_rise <= 1'b0;
      lnk.serial_clock_in_fall <= 1'b0;
      lnk.data_bit <= 1'b0;
      lnk.two_wire <= 1'b0;
      lnk.frame_rst <= 1'b1;
    end
    else
    begin
      serial_clock_in_d <= sync[1];
      quiet_cnt <= edge_now ? '0 : (quiet_full ? quiet_cnt : quiet_cnt + 1'b1);
      lnk.serial_clock_in_rise <= sync[1] & ~serial_clock_in_d;
      lnk.serial_clock_in_fall <= ~sync[1] & serial_clock_in_d;
      lnk.data_bit <= sync[2];
      lnk.two_wire <= sync[3];
      // chip select low or timeout resets
      lnk.frame_rst <= sync[3] ? next_expired : ~sync[0];
    end
  end

  AST_TIMEOUT_RESET: assert property (@(posedge clk) disable iff (!rst_n)
    (sync[3] && quiet_full && !edge_now) |=> lnk.frame_rst)
    else $error("two-wire timeout did not reset the interface");
endmodule // esc_link_front

/* File: bench/esc_ctrl_model.sv */
`timescale 1ns/100ps
module esc_ctrl_model (
  output logic cs, // Chip select to device
  output logic serial_clock_in, // Serial clock to device
  output logic wire_lvl, // Resolved data wire level
  input wire logic dev_out, // Device data drive value
  input wire logic dev_oe_n, // Device data enable, low drives
  input wire logic pin_out, // Programming pin level
  input wire logic chain // Chain output of device
);
  logic ctl_oe = 1'b0;
  logic ctl_val = 1'b0;
  logic flt = 1'b0;
  logic [61:0] rd;
  logic [61:0] rd_pin;
  logic drove = 1'b0;
  logic chain_mid;
  logic chain_end;
  initial
  begin
    cs = 1'b0;
    serial_clock_in = 1'b0;
  end
  // Released wire shows a changing pattern, no pull
  always #37 flt = ~flt;
  assign wire_lvl = !dev_oe_n ? dev_out : (ctl_oe ? ctl_val : flt);
  always @(negedge dev_oe_n) drove = 1'b1;
  // One clock: data set mid low phase, read sampled just before the rise
  task automatic tick(input logic drv, input logic val, input logic samp);
    #100;
    ctl_oe = drv;
    ctl_val = val;
    #100;
    if (samp)
    begin
      rd = {rd[60:0], wire_lvl};
      rd_pin = {rd_pin[60:0], pin_out};
    end
    serial_clock_in = 1'b1;
    #200;
    serial_clock_in = 1'b0;
  endtask
  task automatic frame(input logic two, input logic [4:0] cmd, input logic [61:0] dat,
                       input int nbits, input int sub);
    int i;
    drove = 1'b0;
    rd = '0;
    rd_pin = '0;
    // Keeps every pin change just after a system clock edge
    #150;
    if (!two)
    begin
      cs = 1'b1;
      #400;
    end
    for (i = 0; i < 5; i++)
      tick(1'b1, cmd[4 - i], 1'b0);
    chain_mid = chain;
    for (i = 0; i < nbits * sub; i++)
      tick(cmd[4], dat[nbits - 1 - i / sub], !cmd[4] && (i % sub == 0));
    ctl_oe = 1'b0;
    #400;
    chain_end = chain;
    if (!two)
    begin
      cs = 1'b0;
      #400;
    end
  endtask
endmodule // esc_ctrl_model

/* File: bench/test_encoder_serial_cmd_daisy.sv */
`timescale 1ns/100ps
module test_encoder_serial_cmd_daisy;
  localparam int TOC = 40;
  localparam logic [61:0] FV = 62'h1234_5678_9a9c_def0;
  logic sys_clk, rst_n, cs, serial_clock_in, din, framing, lock, fuse_ok;
  logic [8:0] angle;
  logic [5:0] agc;
  logic dout, doe_n, chain, sleep, srst, ext, strobe, pin, pin_oe_n;
  logic [1:0] hyst;
  logic [8:0] turn;
  logic [61:0] fuse;
  logic [20:0] pdata;
  logic [1:0] hyst_exp [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
  int err_count = 0;
  int check_count = 0;
  int strobes = 0;
  int pin_drives = 0;
  esc_serial_cmd #(.TIMEOUT_CYC(TOC)) u_dut (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .CHIP_SELECT(cs), .SERIAL_CLOCK_IN(serial_clock_in),
    .SERIAL_DATA_IN(din), .SERIAL_DATA_OUT(dout), .SERIAL_DATA_OE_N(doe_n),
    .FRAMING_SELECT(framing), .CHAIN_OUT(chain), .ANGLE_IN(angle), .AGC_IN(agc),
    .LOCK_IN(lock), .FUSE_OK_IN(fuse_ok), .SLEEP_REQUEST(sleep), .SOFT_RESET(srst),
    .HYST_STEPS(hyst), .TURN_COUNT(turn), .EXT_MODE(ext), .FUSE_WORD(fuse),
    .FUSE_PROGRAMMING_PIN_STROBE(strobe), .FUSE_PROGRAMMING_PIN_DATA(pdata), .PROGRAMMING_PIN_OUT(pin),
    .PROGRAMMING_PIN_OE_N(pin_oe_n));
  esc_ctrl_model u_ctrl (
    .cs(cs), .serial_clock_in(serial_clock_in), .wire_lvl(din), .dev_out(dout), .dev_oe_n(doe_n),
    .pin_out(pin), .chain(chain));
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (strobe === 1'b1) strobes++;
  always @(negedge pin_oe_n) pin_drives++;
  task automatic complete_run;
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [61:0] got, input logic [61:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  // Two-wire frames are closed by clock quiet beyond the timeout
  task automatic fr(input logic [4:0] cmd, input logic [61:0] dat, input int n, input int sub);
    u_ctrl.frame(framing, cmd, dat, n, sub);
    if (framing)
      #(TOC * 50 + 1000);
    @(posedge sys_clk);
    #2;
  endtask
  task automatic angle_read(input logic exp_lock);
    fr(esc_pkg::CMD_ANGLE, 62'h0, 16, 1);
    check(u_ctrl.rd[15:0], {exp_lock, 6'h2b, 9'h1a5}, "angle word");
    check(u_ctrl.drove, 1'b1, "read drives wire");
  endtask
  initial
  begin
    #3000000;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
  initial
  begin
    rst_n = 1'b0;
    framing = 1'b0;
    angle = 9'h1a5;
    agc = 6'h2b;
    lock = 1'b1;
    // Startup fuse check reports ok, kept until the next fuse access
    fuse_ok = 1'b1;
    repeat (20) @(posedge sys_clk);
    #2;
    check({doe_n, pin_oe_n, hyst, chain, ext, sleep, srst}, 8'he0, "reset outputs");
    check(fuse, 62'h0, "reset fuse word");
    rst_n = 1'b1;
    repeat (8) @(posedge sys_clk);
    #2;
    angle_read(1'b1);
    check(u_ctrl.chain_mid, 1'b0, "chain idle mid frame");
    check(u_ctrl.chain_end, 1'b1, "chain at cycle end");
    check(chain, 1'b0, "chain after select low");
    // two-step hysteresis change, test bits left zero
    for (int k = 0; k < 4; k++)
    begin
      fr(esc_pkg::CMD_CFG, {2'b01, 2'b00, k[1:0], 10'h0}, 16, 1);
      check(srst, 1'b1, "soft reset set");
      fr(esc_pkg::CMD_CFG, {2'b00, 2'b00, k[1:0], 10'h0}, 16, 1);
      check({srst, hyst}, {1'b0, hyst_exp[k]}, "hysteresis steps");
      check(u_ctrl.drove, 1'b0, "write leaves wire");
    end
    fr(esc_pkg::CMD_CFG, {2'b10, 2'b00, 2'b01, 10'h0}, 16, 1);
    check({sleep, hyst}, 3'b101, "sleep keeps registers");
    angle_read(1'b0);
    fr(esc_pkg::CMD_CFG, {2'b00, 2'b00, 2'b01, 10'h0}, 16, 1);
    check(sleep, 1'b0, "sleep cleared");
    angle_read(1'b1);
    fr(esc_pkg::CMD_TURN_SET, {9'h15a, 7'h0}, 16, 1);
    check(turn, 9'h15a, "turn preset");
    @(posedge sys_clk);
    #2;
    fuse_ok = 1'b0;
    fr(esc_pkg::CMD_TURN_RD, 62'h0, 16, 1);
    check(u_ctrl.rd[15:0], {9'h15a, 1'b1, 6'h0}, "turn read startup flag");
    fr(esc_pkg::CMD_TURN_SET, 62'h0ab, 8, 1);
    check(turn, 9'h15a, "aborted preset");
    angle_read(1'b1);
    fr(esc_pkg::CMD_FUSE_WR, 62'hffff, 16, 1);
    check(fuse, 62'h0, "fuse write outside extended");
    fr(5'h15, 62'hffff, 16, 1);
    check({turn, hyst, ext}, {9'h15a, 2'h1, 1'b0}, "undefined code");
    fr(esc_pkg::CMD_EXT_EN, 62'h8caf, 16, 1);
    check(ext, 1'b0, "wrong key");
    fr(esc_pkg::CMD_EXT_EN, 62'h8cae, 16, 1);
    check(ext, 1'b1, "extended enabled");
    fr(esc_pkg::CMD_FUSE_WR, FV, 62, 4);
    check(fuse, FV, "soft write");
    check(strobes, 0, "soft write no program");
    fr(esc_pkg::CMD_FUSE_RD, 62'h0, 62, 4);
    check(u_ctrl.rd, FV, "fuse read");
    fr(esc_pkg::CMD_FUSE_PROGRAMMING_PIN, FV, 62, 4);
    check({strobes[1:0], pdata}, {2'h1, FV[20:0]}, "program user bits");
    fr(esc_pkg::CMD_FUSE_ANA, 62'h0, 62, 4);
    check(u_ctrl.rd_pin, FV, "analog bit stream");
    check(u_ctrl.drove, 1'b0, "analog no serial data");
    check(pin_drives, 1, "analog pin driven");
    fr(esc_pkg::CMD_FUSE_WR, FV | 62'h20_0000, 62, 4);
    check(fuse, FV | 62'h20_0000, "locked soft write");
    fr(esc_pkg::CMD_FUSE_PROGRAMMING_PIN, FV, 62, 4);
    check(strobes, 1, "program blocked by lock");
    fr(esc_pkg::CMD_TURN_RD, 62'h0, 16, 1);
    check(u_ctrl.rd[15:0], {9'h15a, 1'b0, 6'h0}, "flag after fuse access");
    // single device strapped as two-wire end of chain
    framing = 1'b1;
    #3000;
    angle_read(1'b1);
    check(u_ctrl.chain_mid, 1'b1, "chain set by first fall");
    check(u_ctrl.chain_end, 1'b0, "chain cleared at end");
    fr(esc_pkg::CMD_TURN_SET, 62'h3, 3, 1);
    check(chain, 1'b0, "chain cleared by timeout");
    fr(esc_pkg::CMD_TURN_SET, {9'h0c3, 7'h0}, 16, 1);
    check(turn, 9'h0c3, "frame after timeout");
    complete_run();
  end
endmodule // test_encoder_serial_cmd_daisy
